// *** logic/fan_cfg_core.sv ***
// fan drive limit and frequency configuration with four duty-cycle outputs.
// assumes an APB master on ref_clk and loop inputs from ref_clk logic.
//
// Functional notes
// - below start threshold in automatic mode, drive 0% or floor per hold bit.
// - frequency byte: bits 0,1 hold bits; codes in [4:2] and [7:5].
// - three-bit code picks one of eight low frequencies, 11 to 88.2 Hz.
// - both frequency bytes reset to 0x90.
// - four floor duty registers at 0x28..0x2B reset to 0x80.
// - shared ceiling at 0x2C, reset 0xC0, caps duty in automatic mode.
// - frequency, floor and ceiling obey lock and reload on software reset.
// - control source code 111 selects manual, anything else automatic.
//
// Our own choice: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module fan_cfg_core
  import fan_cfg_pkg::*;
#(
  parameter longint CLK_HZ = 250000000
)
(
  // clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         rst_n,
  // APB slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [ADDR_W-1:0]            paddr,
  input  wire logic [DATA_W-1:0]            pwdata,
  input  wire logic [DATA_W/8-1:0]          pstrb,
  output logic      [DATA_W-1:0]            prdata,
  output logic                              pready,
  output logic                              pslverr,
  // control loop inputs
  input  wire logic [NUM_CH-1:0][REG_W-1:0] auto_demand,
  input  wire logic [NUM_CH-1:0][REG_W-1:0] manual_duty,
  input  wire logic [NUM_CH-1:0]            below_start,
  // fan drive outputs
  output logic                              fan_drive_output_1,
  output logic                              fan_drive_output_2,
  output logic                              fan_drive_output_3,
  output logic                              fan_drive_output_4
);

  localparam int FREQ_REGS = NUM_CH / 2;

  function automatic logic [REG_W-1:0] min8(input logic [REG_W-1:0] a,
                                            input logic [REG_W-1:0] b);
    return (a < b) ? a : b;
  endfunction : min8

  function automatic logic [REG_W-1:0] max8(input logic [REG_W-1:0] a,
                                            input logic [REG_W-1:0] b);
    return (a > b) ? a : b;
  endfunction : max8

  // registers
  logic [FREQ_REGS-1:0][REG_W-1:0] freq_ff;
  logic [NUM_CH-1:0][REG_W-1:0]    floor_ff;
  logic [REG_W-1:0]                ceiling_ff;
  logic [NUM_CH-1:0][CODE_W-1:0]   src_ff;
  logic                            lock_ff;
  logic [NUM_CH-1:0][REG_W-1:0]    duty_ff;
  logic [NUM_CH-1:0][REG_W-1:0]    nxt_duty;
  logic [DATA_W-1:0]               prdata_ff;
  logic                            pready_ff;
  logic                            pslverr_ff;
  logic [DATA_W-1:0]               nxt_prdata;
  logic [NUM_CH-1:0]               pwm_lvl;
  logic [NUM_CH-1:0]               manual_ch;

  duty_if chan [NUM_CH] ();

  // bus decode
  wire [IDX_W-1:0] idx;
  wire             aligned;
  wire             acc_first;
  wire             wr_go;
  wire             lo_byte;
  wire             hit_f12;
  wire             hit_f34;
  wire             hit_floor;
  wire             hit_ceil;
  wire             hit_src;
  wire             hit_ctrl;
  wire             hit_stat;
  wire             mapped;
  wire             cfg_wr;
  wire             sw_reset;
  wire             lock_set;
  wire [REG_W-1:0] status;
  wire [REG_W-1:0] ctrl_rd;

  assign idx       = paddr[ADDR_W-1:2];
  assign aligned   = (paddr[1:0] == 2'b00);
  assign acc_first = psel & penable & ~pready_ff;
  assign wr_go     = psel & penable & pready_ff & pwrite & ~pslverr_ff;
  assign lo_byte   = pstrb[0];
  assign hit_f12   = aligned & (idx == IDX_FREQ_12);
  assign hit_f34   = aligned & (idx == IDX_FREQ_34);
  assign hit_floor = aligned & (idx >= IDX_FLOOR_1) & (idx <= IDX_FLOOR_4);
  assign hit_ceil  = aligned & (idx == IDX_CEILING);
  assign hit_src   = aligned & (idx == IDX_SRC_SEL);
  assign hit_ctrl  = aligned & (idx == IDX_CONTROL);
  assign hit_stat  = aligned & (idx == IDX_STATUS);
  assign mapped    = hit_f12 | hit_f34 | hit_floor | hit_ceil | hit_src
                   | hit_ctrl | hit_stat;
  assign cfg_wr    = wr_go & lo_byte & ~lock_ff;
  assign sw_reset  = wr_go & lo_byte & hit_ctrl & pwdata[CTRL_SWRST_BIT];
  assign lock_set  = wr_go & lo_byte & hit_ctrl & pwdata[CTRL_LOCK_BIT];

  assign status  = {pwm_lvl, manual_ch};
  assign ctrl_rd = REG_W'({lock_ff} << CTRL_LOCK_BIT);

  // floor registers are consecutive, so the low index bits pick the channel
  assign nxt_prdata =
      hit_f12   ? DATA_W'(freq_ff[0])      :
      hit_f34   ? DATA_W'(freq_ff[1])      :
      hit_floor ? DATA_W'(floor_ff[idx[1:0]]) :
      hit_ceil  ? DATA_W'(ceiling_ff)      :
      hit_src   ? DATA_W'(src_ff)          :
      hit_ctrl  ? DATA_W'(ctrl_rd)         :
      hit_stat  ? DATA_W'(status)          :
                  {DATA_W{1'b0}};

  // one wait state: the answer is registered so the outputs come from flops
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= {DATA_W{1'b0}};
    end
    else
    begin
      pready_ff  <= acc_first;
      pslverr_ff <= acc_first & ~mapped;
      prdata_ff  <= (acc_first & ~pwrite) ? nxt_prdata : {DATA_W{1'b0}};
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;

  // frequency bytes
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      freq_ff <= {FREQ_REGS{FREQ_RST}};
    else if (sw_reset)
      freq_ff <= {FREQ_REGS{FREQ_RST}};
    else if (cfg_wr & hit_f12)
      freq_ff[0] <= pwdata[REG_W-1:0];
    else if (cfg_wr & hit_f34)
      freq_ff[1] <= pwdata[REG_W-1:0];
  end

  // floor duty registers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      floor_ff <= {NUM_CH{FLOOR_RST}};
    else if (sw_reset)
      floor_ff <= {NUM_CH{FLOOR_RST}};
    else if (cfg_wr & hit_floor)
      floor_ff[idx[1:0]] <= pwdata[REG_W-1:0];
  end

  // shared ceiling
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      ceiling_ff <= CEILING_RST;
    else if (sw_reset)
      ceiling_ff <= CEILING_RST;
    else if (cfg_wr & hit_ceil)
      ceiling_ff <= pwdata[REG_W-1:0];
  end

  // control source select is not under the lock
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      src_ff <= SRC_RST;
    else if (sw_reset)
      src_ff <= SRC_RST;
    else if (wr_go & lo_byte & hit_src)
      src_ff <= pwdata[SRC_W-1:0];
  end

  // lock is write-once; only the hardware reset releases it
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      lock_ff <= 1'b0;
    else if (lock_set)
      lock_ff <= 1'b1;
  end

  // per-channel duty selection
  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_ch
    localparam int FR  = i / 2;
    localparam int HB  = (i % 2 == 0) ? HOLD_A_BIT : HOLD_B_BIT;
    localparam int CL  = (i % 2 == 0) ? CODE_A_LSB : CODE_B_LSB;

    wire             hold;
    wire [REG_W-1:0] run_duty;
    wire [REG_W-1:0] idle_duty;
    wire [REG_W-1:0] auto_duty;

    assign hold      = freq_ff[FR][HB];
    assign manual_ch[i] = (src_ff[i] == SRC_MANUAL);
    assign run_duty  = max8(auto_demand[i], floor_ff[i]);
    assign idle_duty = hold ? floor_ff[i] : DUTY_OFF;
    assign auto_duty = below_start[i] ? idle_duty : run_duty;
    assign nxt_duty[i] = manual_ch[i] ? manual_duty[i]
                                       : min8(auto_duty, ceiling_ff);

    assign chan[i].duty = duty_ff[i];
    assign chan[i].code = freq_ff[FR][CL +: CODE_W];
    assign pwm_lvl[i]   = chan[i].pwm;

    fan_pwm_gen #(
      .CLK_HZ (CLK_HZ)
    ) u_gen (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .chan    (chan[i])
    );
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      duty_ff <= {NUM_CH{DUTY_OFF}};
    else
      duty_ff <= nxt_duty;
  end

  assign fan_drive_output_1 = pwm_lvl[0];
  assign fan_drive_output_2 = pwm_lvl[1];
  assign fan_drive_output_3 = pwm_lvl[2];
  assign fan_drive_output_4 = pwm_lvl[3];

endmodule : fan_cfg_core
`default_nettype wire

// *** logic/fan_cfg_top_unused_placeholder_removed.sv ***
// intentionally empty compilation unit kept off; holds no design
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// *** logic/fan_pwm_gen.sv ***
// one low-frequency duty-cycle generator.
// assumes duty and code come from ref_clk logic; they are taken at period end.
`timescale 1ns/10ps
`default_nettype none
module fan_pwm_gen
  import fan_cfg_pkg::*;
#(
  parameter longint CLK_HZ = 250000000
)
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // settings in, drive out
  duty_if.gen       chan
);

  function automatic logic [31:0] period_of(input logic [CODE_W-1:0] code);
    longint p;
    p = (CLK_HZ * CHZ_PER_HZ) / longint'(FREQ_CHZ[code]);
    return p[31:0];
  endfunction : period_of

  localparam logic [31:0] PERIOD_RST = period_of(CODE_RST);

  logic [31:0]      cnt_ff;
  logic [31:0]      period_ff;
  logic [REG_W-1:0] duty_ff;
  logic             pwm_ff;
  longint           high_prod;
  wire              period_end;
  wire  [31:0]      high_len;

  assign period_end = (cnt_ff >= period_ff - 32'h1);
  assign high_prod  = longint'(period_ff) * longint'(duty_ff);
  assign high_len   = 32'(high_prod >> DUTY_SHIFT);
  assign chan.pwm   = pwm_ff;

  // new code and duty are adopted only at a period boundary, so no runt pulses
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_ff    <= 32'h0;
      period_ff <= PERIOD_RST;
      duty_ff   <= DUTY_OFF;
    end
    else if (period_end)
    begin
      cnt_ff    <= 32'h0;
      period_ff <= period_of(chan.code);
      duty_ff   <= chan.duty;
    end
    else
    begin
      cnt_ff <= cnt_ff + 32'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      pwm_ff <= 1'b0;
    else
      pwm_ff <= (cnt_ff < high_len);
  end

endmodule : fan_pwm_gen
`default_nettype wire

// *** pkg/duty_if.sv ***
// carrier between the configuration core and one duty-cycle generator.
// assumes both ends run on ref_clk.
`timescale 1ns/10ps
`default_nettype none
interface duty_if;
  import fan_cfg_pkg::*;
  logic [REG_W-1:0]  duty;
  logic [CODE_W-1:0] code;
  logic              pwm;
  modport ctrl (output duty, output code, input pwm);
  modport gen  (input duty, input code, output pwm);
endinterface : duty_if
`default_nettype wire

// *** pkg/fan_cfg_pkg.sv ***
// fan drive configuration constants: register map, field layout, reset values,
// low-frequency table. assumes a word-aligned APB map with byte-wide registers except the 12-bit source select.
package fan_cfg_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 10;
  localparam int IDX_W  = 8;
  localparam int REG_W  = 8;
  localparam int NUM_CH = 4;
  localparam int CODE_W = 3;
  localparam int SRC_W  = NUM_CH * CODE_W;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_FREQ_12 = 8'h25;
  localparam logic [IDX_W-1:0] IDX_FREQ_34 = 8'h26;
  localparam logic [IDX_W-1:0] IDX_FLOOR_1 = 8'h28;
  localparam logic [IDX_W-1:0] IDX_FLOOR_2 = 8'h29;
  localparam logic [IDX_W-1:0] IDX_FLOOR_3 = 8'h2A;
  localparam logic [IDX_W-1:0] IDX_FLOOR_4 = 8'h2B;
  localparam logic [IDX_W-1:0] IDX_CEILING = 8'h2C;
  localparam logic [IDX_W-1:0] IDX_SRC_SEL = 8'h40;
  localparam logic [IDX_W-1:0] IDX_CONTROL = 8'h41;
  localparam logic [IDX_W-1:0] IDX_STATUS  = 8'h42;

  // reset values
  localparam logic [REG_W-1:0]  FREQ_RST    = 8'h90;
  localparam logic [REG_W-1:0]  FLOOR_RST   = 8'h80;
  localparam logic [REG_W-1:0]  CEILING_RST = 8'hC0;
  localparam logic [SRC_W-1:0]  SRC_RST     = 12'h000;
  localparam logic [CODE_W-1:0] CODE_RST    = 3'h4;
  localparam logic [REG_W-1:0]  DUTY_OFF    = 8'h00;

  // frequency byte layout: first channel low, second channel high
  localparam int HOLD_A_BIT = 0;
  localparam int HOLD_B_BIT = 1;
  localparam int CODE_A_LSB = 2;
  localparam int CODE_B_LSB = 5;

  // control register bits
  localparam int CTRL_LOCK_BIT  = 0;
  localparam int CTRL_SWRST_BIT = 1;

  // control source code that selects manual drive
  localparam logic [CODE_W-1:0] SRC_MANUAL = 3'h7;

  // duty codes are a fraction of 2**DUTY_SHIFT
  localparam int DUTY_SHIFT = 8;

  // low-frequency table in hundredths of a hertz, indexed by code
  localparam int FREQ_CHZ [8] = '{1100, 1470, 2210, 2940, 3530, 4410, 5880, 8820};
  localparam longint CHZ_PER_HZ = 100;

endpackage : fan_cfg_pkg

// *** verif/fan_cfg_core_sva.sv ***
// checker for the fan configuration block: apb answer timing and error flags.
// assumes it is bound to fan_cfg_core and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module fan_cfg_core_sva
  import fan_cfg_pkg::*;
#(
  parameter longint CLK_HZ = 250000000
)
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // apb
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] prdata,
  input  wire logic              pready,
  input  wire logic              pslverr
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence first_access;
    psel && !penable ##1 psel && penable && !pready;
  endsequence
  chk_answer_delay: assert property (first_access |=> pready)
    else $error("answer not one cycle after access");
  chk_answer_pulse: assert property (pready |=> !pready)
    else $error("answer held too long");
  chk_answer_cause: assert property (pready |-> $past(psel && penable) && penable)
    else $error("answer without access");
  chk_error_marker: assert property (pslverr |-> pready)
    else $error("error flag without answer");
  chk_quiet_data: assert property (!pready |-> prdata == '0)
    else $error("read data outside answer");
  chk_upper_zero: assert property (pready |-> prdata[DATA_W-1:REG_W] == '0)
    else $error("upper read bits not zero");
  chk_gap_error: assert property (pready && paddr == 10'h09C |-> pslverr)
    else $error("gap address accepted");
  chk_ceiling_mapped: assert property (pready && paddr == 10'h0B0 |-> !pslverr)
    else $error("ceiling address refused");
endmodule : fan_cfg_core_sva
bind fan_cfg_core fan_cfg_core_sva #(.CLK_HZ(CLK_HZ)) sva (.ref_clk(ref_clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr));
`default_nettype wire

// *** verif/fan_load.sv ***
// fan load model: measures period and high time of one drive output.
// assumes the drive output changes on ref_clk.
`timescale 1ns/10ps
`default_nettype none
module fan_load
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // drive and measurements
  input  wire logic pwm,
  output var  int   period,
  output var  int   high,
  output var  int   rises
);
  int   cnt;
  int   hcnt;
  logic pwm_q;
  wire  rise = pwm && !pwm_q;
  always @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      {period, high, rises, cnt, hcnt} <= '0;
      pwm_q <= 1'b0;
    end
    else
    begin
      pwm_q <= pwm;
      cnt   <= rise ? 1 : cnt + 1;
      hcnt  <= rise ? 1 : hcnt + int'(pwm);
      if (rise)
      begin
        period <= cnt;
        high   <= hcnt;
        rises  <= rises + 1;
      end
    end
endmodule : fan_load
`default_nettype wire

// *** verif/tb_fan_pwm_limit_and_frequency_config.sv ***
// bench for the fan limit and frequency block: registers over apb, all four drive waveforms.
// assumes a shortened clock parameter so the low-frequency periods stay short.
`timescale 1ns/10ps
`default_nettype none
module tb_fan_pwm_limit_and_frequency_config;
  import fan_cfg_pkg::*;
  localparam longint CLK = 25000;
  localparam int     P7  = int'(CLK * CHZ_PER_HZ / FREQ_CHZ[7]);
  localparam int     P4  = int'(CLK * CHZ_PER_HZ / FREQ_CHZ[4]);
  logic                         ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
  logic [ADDR_W-1:0]            paddr;
  logic [DATA_W-1:0]            pwdata, prdata, rd;
  logic [NUM_CH-1:0][REG_W-1:0] demand, manual;
  logic [NUM_CH-1:0]            below;
  wire  [NUM_CH-1:0]            fan;
  int                           period [NUM_CH];
  int                           high [NUM_CH];
  int                           rises [NUM_CH];
  int                           n_errors, num_checks;
  fan_cfg_core #(.CLK_HZ(CLK)) uut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .auto_demand(demand),
    .manual_duty(manual), .below_start(below), .fan_drive_output_1(fan[0]),
    .fan_drive_output_2(fan[1]), .fan_drive_output_3(fan[2]), .fan_drive_output_4(fan[3]));
  // one load model per drive output
  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_load
    fan_load load (.ref_clk(ref_clk), .rst_n(rst_n), .pwm(fan[g]), .period(period[g]),
      .high(high[g]), .rises(rises[g]));
  end
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one apb transfer; answer taken at the edge where pready is high
  task automatic apb(input logic w, input logic [IDX_W-1:0] i, input logic [DATA_W-1:0] d);
    int k;
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {i, 2'b00};
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // pready and read data are both taken at the same rising edge
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
    begin
      n_errors++;
      test_done;
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input logic [IDX_W-1:0] i, input logic [REG_W-1:0] e);
    apb(1'b0, i, '0);
    chk(rd, DATA_W'(e));
  endtask : rdchk
  // skip adoption of new settings, then judge one whole period
  task automatic see(input int ch, input int p, input int h);
    int k;
    int t0;
    t0 = rises[ch];
    for (k = 0; k < 30000 && rises[ch] < t0 + 3; k++)
      @(posedge ref_clk);
    if (k == 30000)
    begin
      n_errors++;
      test_done;
    end
    chk(period[ch], p);
    chk(high[ch], h);
  endtask : see
  task automatic t_reset;
    rdchk(IDX_FREQ_12, FREQ_RST);
    rdchk(IDX_FREQ_34, FREQ_RST);
    for (int i = 0; i < NUM_CH; i++)
      rdchk(IDX_W'(IDX_FLOOR_1 + i), FLOOR_RST);
    rdchk(IDX_CEILING, CEILING_RST);
  endtask : t_reset
  task automatic t_freq;
    logic [REG_W-1:0] v;
    int               p;
    int               q;
    for (int c = 0; c < 8; c++)
    begin
      v = {3'(7 - c), 3'(c), 2'b00};
      apb(1'b1, IDX_FREQ_12, DATA_W'(v));
      rdchk(IDX_FREQ_12, v);
      p = int'(CLK * CHZ_PER_HZ / FREQ_CHZ[c]);
      q = int'(CLK * CHZ_PER_HZ / FREQ_CHZ[7 - c]);
      see(0, p, p * 128 / 256);
      see(1, q, q * 128 / 256);
    end
    see(2, P4, P4 * 128 / 256);
    see(3, P4, P4 * 128 / 256);
  endtask : t_freq
  task automatic t_duty;
    int h;
    apb(1'b1, IDX_FREQ_12, 32'h9C);
    demand <= {4{8'hFF}};
    see(0, P7, P7 * 192 / 256);
    apb(1'b1, IDX_CEILING, 32'hFF);
    see(0, P7, P7 * 255 / 256);
    below <= 4'hF;
    // the slowest channels need up to one old period before going idle
    repeat (2 * P4) @(negedge ref_clk);
    h = 0;
    repeat (P4) @(negedge ref_clk) h += int'(|fan);
    chk(h, 0);
    apb(1'b1, IDX_FLOOR_1, 32'h40);
    apb(1'b1, IDX_FREQ_12, 32'h9D);
    see(0, P7, P7 * 64 / 256);
    below <= 4'h0;
    apb(1'b1, IDX_CEILING, 32'h80);
    apb(1'b1, IDX_SRC_SEL, 32'h7);
    see(0, P7, P7 * 224 / 256);
    apb(1'b1, IDX_SRC_SEL, 32'h6);
    see(0, P7, P7 * 128 / 256);
  endtask : t_duty
  task automatic t_map_lock;
    apb(1'b0, 8'h27, '0);
    chk(rd, '0);
    chk(DATA_W'(er), 32'h1);
    apb(1'b1, IDX_CONTROL, 32'h1);
    apb(1'b1, IDX_FLOOR_2, 32'h11);
    rdchk(IDX_FLOOR_2, FLOOR_RST);
    apb(1'b1, IDX_CEILING, 32'h22);
    rdchk(IDX_CEILING, 8'h80);
    apb(1'b1, IDX_CONTROL, 32'h2);
    rdchk(IDX_CEILING, CEILING_RST);
    rdchk(IDX_FLOOR_1, FLOOR_RST);
    rdchk(IDX_FREQ_12, FREQ_RST);
  endtask : t_map_lock
  initial
  begin
    {n_errors, num_checks} = '0;
    {rst_n, psel, penable, pwrite, paddr, pwdata, below} = '0;
    demand = {4{8'h60}};
    manual = {4{8'hE0}};
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset;
    t_freq;
    t_duty;
    t_map_lock;
    test_done;
  end
endmodule : tb_fan_pwm_limit_and_frequency_config
`default_nettype wire
